// >>> design/pattern_output_pkg.sv
// Function
// - sixteen outputs form four 4-bit groups updating simultaneously and independently
// - each group picks its trigger from four timer channel compare strobes
// - pattern output enabled per bit; other bits behave as ordinary port bits
// - optional non-overlap mode delays rising edges by a margin after falls
// - a group's selected compare strobe also raises a dma request
// - each direction register is 8-bit, write-only, cleared to zero at reset
// - low port value holds groups 0 and 1, high port value groups 2, 3
// - port value bits with pattern output enabled ignore writes; others stay writable
// - selected trigger copies staged low-byte bits into low port value bits
// - staged low byte is 8 bits, cleared by reset and hardware standby
// - groups 0,1 shared trigger: one byte at 0xffa5, 0xffa7 reads all ones
// - groups 0,1 split: group 1 upper 0xffa5, group 0 lower 0xffa7, rest ones
// - groups 2,3 shared at 0xffa4; split: group 3 at 0xffa4, group 2 0xffa6
// - register decode uses only the lower sixteen address bits
// - selected trigger copies staged high-byte bits into high port value bits
// - bits with output enable clear are never copied; port value unchanged
// - two-bit field per group selects channel 0-3; reset all ones selects 3
package pattern_output_pkg;

   // register offsets, lower sixteen address bits
   localparam logic [15:0] ADDR_MODE = 16'hffa0;
   localparam logic [15:0] ADDR_TRIG_SEL = 16'hffa1;
   localparam logic [15:0] ADDR_OE_HIGH = 16'hffa2;
   localparam logic [15:0] ADDR_OE_LOW = 16'hffa3;
   localparam logic [15:0] ADDR_STAGED_HIGH = 16'hffa4;
   localparam logic [15:0] ADDR_STAGED_LOW = 16'hffa5;
   localparam logic [15:0] ADDR_STAGED_G2 = 16'hffa6;
   localparam logic [15:0] ADDR_STAGED_G0 = 16'hffa7;
   localparam logic [15:0] ADDR_LOW_DIR = 16'hffd1;
   localparam logic [15:0] ADDR_LOW_VALUE = 16'hffd3;
   localparam logic [15:0] ADDR_HIGH_DIR = 16'hffd4;
   localparam logic [15:0] ADDR_HIGH_VALUE = 16'hffd6;

   // reset values
   localparam logic [7:0] RST_MODE = 8'hf0;
   localparam logic [7:0] RST_TRIG_SEL = 8'hff;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] READ_ONES = 8'hff;
   localparam logic [3:0] NIBBLE_ONES = 4'hf;

   // field layout
   localparam int GROUPS = 4;
   localparam int GROUP_BITS = 4;
   localparam int SEL_BITS = 2;
   localparam int PINS = GROUPS * GROUP_BITS;

   // non-overlap margin, least time, rounded up to whole cycles
   localparam int CLK_PERIOD_PS = 8000;
   localparam int NOV_MARGIN_PS = 32000;
   localparam int NOV_MARGIN_CYCLES = (NOV_MARGIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // one register-port request
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

endpackage

// >>> design/pattern_output_unit.sv
// Our own choice: the address-and-strobe port.
module pattern_output_unit
   import pattern_output_pkg::*;
#(
   parameter int NOV_CYCLES = NOV_MARGIN_CYCLES
) (
   input wire logic i_clk_sys, // 125 MHz system clock
   input wire logic i_rst_n, // async reset, active low
   input wire logic i_hw_standby, // hardware standby, clears registers
   input wire logic [31:0] i_addr, // register address
   input wire logic [7:0] i_wdata, // register write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   output logic [7:0] o_rdata, // read data, cycle after strobe
   input wire logic [3:0] i_cmp_match, // timer channel compare strobes
   output logic [3:0] o_dma_req, // per-group dma request pulse
   input wire logic [15:0] i_pin_in, // pin levels, asynchronous
   output logic [15:0] o_pin_out, // pin drive value
   output logic [15:0] o_pin_oe // pin output enable
);

   // the margin counter is eight bits wide
   initial begin
      if (NOV_CYCLES < 1 || NOV_CYCLES > 255) begin
         $error("NOV_CYCLES out of range");
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers
   logic [3:0] mode; // non-overlap enable per group
   logic [7:0] trig_sel;
   logic [15:0] oe_bits; // pattern output enable per bit
   logic [15:0] staged;
   logic [15:0] dir;
   logic [15:0] port_val;
   logic [15:0] pend; // rising bits waiting for the margin
   logic [7:0] nov_cnt [GROUPS];
   logic [3:0] dma_req;
   logic [15:0] pin_s1, pin_s2, pin_s3, pin_lvl;

   ////////////////////////////////////////////////////////////////////////////////
   // address decode on the low half only
   reg_req_s req;
   assign req = '{addr: i_addr[15:0], wdata: i_wdata, wr: i_wr, rd: i_rd};

   wire shared_low = trig_sel[1:0] == trig_sel[3:2];
   wire shared_high = trig_sel[5:4] == trig_sel[7:6];
   wire hit_mode = req.addr == ADDR_MODE;
   wire hit_sel = req.addr == ADDR_TRIG_SEL;
   wire hit_oe_h = req.addr == ADDR_OE_HIGH;
   wire hit_oe_l = req.addr == ADDR_OE_LOW;
   wire hit_stg_h = req.addr == ADDR_STAGED_HIGH;
   wire hit_stg_l = req.addr == ADDR_STAGED_LOW;
   wire hit_stg_g2 = req.addr == ADDR_STAGED_G2;
   wire hit_stg_g0 = req.addr == ADDR_STAGED_G0;
   wire hit_dir_l = req.addr == ADDR_LOW_DIR;
   wire hit_val_l = req.addr == ADDR_LOW_VALUE;
   wire hit_dir_h = req.addr == ADDR_HIGH_DIR;
   wire hit_val_h = req.addr == ADDR_HIGH_VALUE;

   // staged nibble write enables follow the trigger sharing
   wire [3:0] stg_we;
   assign stg_we[0] = req.wr & ((hit_stg_l & shared_low) | (hit_stg_g0 & ~shared_low));
   assign stg_we[1] = req.wr & hit_stg_l;
   assign stg_we[2] = req.wr & ((hit_stg_h & shared_high) | (hit_stg_g2 & ~shared_high));
   assign stg_we[3] = req.wr & hit_stg_h;
   wire [3:0][3:0] stg_wdata;
   assign stg_wdata[0] = hit_stg_g0 ? req.wdata[3:0] : req.wdata[3:0];
   assign stg_wdata[1] = req.wdata[7:4];
   assign stg_wdata[2] = req.wdata[3:0];
   assign stg_wdata[3] = req.wdata[7:4];

   ////////////////////////////////////////////////////////////////////////////////
   // read mux; reserved nibbles read as ones
   wire [7:0] rd_stg_l = shared_low ? staged[7:0] : {staged[7:4], NIBBLE_ONES};
   wire [7:0] rd_stg_g0 = shared_low ? READ_ONES : {NIBBLE_ONES, staged[3:0]};
   wire [7:0] rd_stg_h = shared_high ? staged[15:8] : {staged[15:12], NIBBLE_ONES};
   wire [7:0] rd_stg_g2 = shared_high ? READ_ONES : {NIBBLE_ONES, staged[11:8]};
   // input bits read the pin, output bits read the register
   wire [15:0] port_rd = (port_val & dir) | (pin_lvl & ~dir);
   logic [7:0] rd_mux;
   always_comb begin
      case (1'b1)
         hit_mode: rd_mux = {NIBBLE_ONES, mode};
         hit_sel: rd_mux = trig_sel;
         hit_oe_h: rd_mux = oe_bits[15:8];
         hit_oe_l: rd_mux = oe_bits[7:0];
         hit_stg_h: rd_mux = rd_stg_h;
         hit_stg_l: rd_mux = rd_stg_l;
         hit_stg_g2: rd_mux = rd_stg_g2;
         hit_stg_g0: rd_mux = rd_stg_g0;
         hit_val_l: rd_mux = port_rd[7:0];
         hit_val_h: rd_mux = port_rd[15:8];
         default: rd_mux = READ_ONES; // write-only and unmapped read ones
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= RST_ZERO;
      end else begin
         o_rdata <= req.rd ? rd_mux : RST_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin input synchroniser; a change counts once stages two and three agree
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         pin_s3 <= '0;
         pin_lvl <= '0;
      end else begin
         pin_s1 <= i_pin_in;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         pin_lvl <= (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 ^ pin_s3));
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control registers; hardware standby clears, software standby is not seen here
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode <= RST_MODE[3:0];
         trig_sel <= RST_TRIG_SEL;
         oe_bits <= '0;
         dir <= '0;
      end else if (i_hw_standby) begin
         mode <= RST_MODE[3:0];
         trig_sel <= RST_TRIG_SEL;
         oe_bits <= '0;
         dir <= '0;
      end else begin
         if (req.wr & hit_mode) mode <= req.wdata[3:0];
         if (req.wr & hit_sel) trig_sel <= req.wdata;
         if (req.wr & hit_oe_h) oe_bits[15:8] <= req.wdata;
         if (req.wr & hit_oe_l) oe_bits[7:0] <= req.wdata;
         if (req.wr & hit_dir_l) dir[7:0] <= req.wdata;
         if (req.wr & hit_dir_h) dir[15:8] <= req.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // per-group trigger, copy and non-overlap logic
   // nets, so each group drives only its own slice
   wire [15:0] next_port_val;
   wire [15:0] next_pend;
   wire [15:0] next_staged;
   wire [3:0] trig;

   // cpu write to port value: only bits without pattern output take it
   wire [15:0] cpu_val_we = {{8{req.wr & hit_val_h}}, {8{req.wr & hit_val_l}}} & ~oe_bits;
   wire [15:0] cpu_val = (port_val & ~cpu_val_we) | ({req.wdata, req.wdata} & cpu_val_we);

   genvar g;
   generate
      for (g = 0; g < GROUPS; g++) begin : grp
         localparam int LO = g * GROUP_BITS;
         wire [1:0] sel = trig_sel[g*SEL_BITS +: SEL_BITS];
         wire [3:0] en = oe_bits[LO +: GROUP_BITS];
         wire [3:0] stg = staged[LO +: GROUP_BITS];
         wire [3:0] cur = cpu_val[LO +: GROUP_BITS];
         wire margin_end = nov_cnt[g] == 8'h01;
         wire [3:0] plain_copy = (stg & en) | (cur & ~en);
         wire [3:0] fall_only = (stg & cur & en) | (cur & ~en);
         assign trig[g] = i_cmp_match[sel];
         // old staged nibble is used even when a write lands now
         assign next_staged[LO +: GROUP_BITS] = stg_we[g] ? stg_wdata[g] : stg;
         logic [3:0] next_grp_val;
         logic [3:0] next_grp_pend;
         assign next_port_val[LO +: GROUP_BITS] = next_grp_val;
         assign next_pend[LO +: GROUP_BITS] = next_grp_pend;
         always_comb begin
            next_grp_val = cur;
            next_grp_pend = pend[LO +: GROUP_BITS];
            if (margin_end) begin
               // rise pending bits still enabled after the margin
               next_grp_val = cur | (pend[LO +: GROUP_BITS] & en);
               next_grp_pend = '0;
            end
            if (trig[g] && !mode[g]) begin
               next_grp_val = plain_copy;
               next_grp_pend = '0;
            end else if (trig[g] && mode[g]) begin
               next_grp_val = fall_only;
               next_grp_pend = stg & en;
            end
         end
         // margin counter restarts on every trigger in non-overlap mode
         always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
            if (!i_rst_n) begin
               nov_cnt[g] <= 8'h00;
            end else if (i_hw_standby) begin
               nov_cnt[g] <= 8'h00;
            end else if (trig[g] && mode[g]) begin
               nov_cnt[g] <= 8'(NOV_CYCLES);
            end else if (nov_cnt[g] != 8'h00) begin
               nov_cnt[g] <= nov_cnt[g] - 8'h01;
            end
         end
      end
   endgenerate

   // staged data, port values and dma pulses
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         staged <= '0;
         port_val <= '0;
         pend <= '0;
         dma_req <= '0;
      end else if (i_hw_standby) begin
         staged <= '0;
         port_val <= '0;
         pend <= '0;
         dma_req <= '0;
      end else begin
         staged <= next_staged;
         port_val <= next_port_val;
         pend <= next_pend;
         dma_req <= trig;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin drive; direction must be set by software for pattern pins
   assign o_pin_out = port_val;
   assign o_pin_oe = dir;
   assign o_dma_req = dma_req;

endmodule

// >>> test/pattern_output_props.sv
module pattern_output_props
   import pattern_output_pkg::*;
#(
   parameter int NOV_CYCLES = NOV_MARGIN_CYCLES
) (
   input wire logic i_clk_sys, // clock
   input wire logic i_rst_n, // reset, active low
   input wire logic i_hw_standby, // standby clear
   input wire logic [31:0] i_addr, // address
   input wire logic [7:0] i_wdata, // write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   input wire logic [7:0] o_rdata, // read data
   input wire logic [3:0] i_cmp_match, // compare strobes
   input wire logic [3:0] o_dma_req, // dma pulses
   input wire logic [15:0] i_pin_in, // pin levels
   input wire logic [15:0] o_pin_out, // pin values
   input wire logic [15:0] o_pin_oe // pin enables
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   wire logic [15:0] low_addr = i_addr[15:0];
   wire logic rd_ok = i_rd && !i_hw_standby;
   wire logic dir_wr = i_wr && (low_addr == ADDR_LOW_DIR || low_addr == ADDR_HIGH_DIR);
   logic [3:0] quiet;
   // cycles since anything could move the port value; saturates so it never wraps
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) quiet <= 4'h0;
      else if (i_cmp_match != 4'h0 || i_wr || i_hw_standby) quiet <= 4'h0;
      else if (quiet != 4'hf) quiet <= quiet + 4'h1;
   end
   property upper_ones(logic [15:0] a);
      rd_ok && low_addr == a |=> o_rdata[7:4] == NIBBLE_ONES;
   endproperty
   a_dir_write_only: assert property (rd_ok && low_addr == ADDR_LOW_DIR |=> o_rdata == READ_ONES)
      else $error("direction read not all ones");
   a_dir_low_takes: assert property (i_wr && !i_hw_standby && low_addr == ADDR_LOW_DIR
      |=> o_pin_oe[7:0] == $past(i_wdata))
      else $error("low direction write lost");
   a_oe_cause: assert property ($changed(o_pin_oe) |-> $past(dir_wr) || $past(i_hw_standby))
      else $error("pin enable moved without a write");
   a_g0_reserved: assert property (upper_ones(ADDR_STAGED_G0))
      else $error("group 0 alternate byte upper nibble not ones");
   a_g2_reserved: assert property (upper_ones(ADDR_STAGED_G2))
      else $error("group 2 alternate byte upper nibble not ones");
   a_mode_upper: assert property (upper_ones(ADDR_MODE))
      else $error("mode upper nibble not ones");
   a_dma_cause: assert property (o_dma_req != 4'h0 |-> $past(i_cmp_match) != 4'h0)
      else $error("dma request without a compare strobe");
   a_standby_clear: assert property (i_hw_standby
      |=> o_pin_out == 16'h0000 && o_pin_oe == 16'h0000 && o_dma_req == 4'h0)
      else $error("standby left state behind");
   a_port_holds: assert property (quiet > NOV_CYCLES + 1 |-> $stable(o_pin_out))
      else $error("port value moved with no cause");
   c_dma: cover property (o_dma_req != 4'h0);
   c_oe_write: cover property (dir_wr);
   c_standby: cover property (i_hw_standby);
endmodule
bind pattern_output_unit pattern_output_props #(.NOV_CYCLES(NOV_CYCLES)) i_props (
   .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_hw_standby(i_hw_standby), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp_match(i_cmp_match),
   .o_dma_req(o_dma_req), .i_pin_in(i_pin_in), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));

// >>> test/timer_strobe_model.sv
module timer_strobe_model (
   input wire logic i_clk_sys, // clock
   input wire logic i_rst_n, // reset, active low
   input wire logic [3:0] i_fire, // channels to match next
   output logic [3:0] o_cmp_match // compare strobes
);
   timeunit 1ns;
   timeprecision 1ps;
   // registered so every strobe is clean and lasts as many whole cycles as i_fire
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) o_cmp_match <= 4'h0;
      else o_cmp_match <= i_fire;
   end
endmodule

// >>> test/pattern_output_unit_bench.sv
module pattern_output_unit_bench;
   import pattern_output_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [15:0] addr; logic [7:0] exp;} row_s;
   logic clk = 0, rst_n = 0, stby = 0, wr = 0, rd = 0;
   logic [31:0] addr = 0;
   logic [7:0] wdata = 0, rdata;
   logic [15:0] pins = 0;
   logic [3:0] fire = 0, cmp, dma;
   logic [15:0] pin_out, pin_oe;
   int miscompares = 0, check_count = 0;
   // reset contents; unmapped 0xffb0 and write-only bytes read ones
   row_s rows[13] = '{'{ADDR_MODE, RST_MODE}, '{ADDR_TRIG_SEL, RST_TRIG_SEL},
      '{ADDR_OE_HIGH, 8'h00}, '{ADDR_OE_LOW, 8'h00}, '{ADDR_STAGED_HIGH, 8'h00},
      '{ADDR_STAGED_LOW, 8'h00}, '{ADDR_STAGED_G2, 8'hff}, '{ADDR_STAGED_G0, 8'hff},
      '{ADDR_LOW_DIR, 8'hff}, '{ADDR_HIGH_DIR, 8'hff}, '{ADDR_LOW_VALUE, 8'h00},
      '{ADDR_HIGH_VALUE, 8'h00}, '{16'hffb0, 8'hff}};
   pattern_output_unit #(.NOV_CYCLES(1)) i_dut (.i_clk_sys(clk), .i_rst_n(rst_n),
      .i_hw_standby(stby), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_cmp_match(cmp), .o_dma_req(dma), .i_pin_in(pins),
      .o_pin_out(pin_out), .o_pin_oe(pin_oe));
   timer_strobe_model i_timer (.i_clk_sys(clk), .i_rst_n(rst_n), .i_fire(fire),
      .o_cmp_match(cmp));
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // bus tasks start just after an edge and end just after one; upper address bits are junk
   task automatic wreg(input logic [15:0] a, input logic [7:0] v);
      wr <= 1; addr <= {16'habcd, a}; wdata <= v;
      @(posedge clk); wr <= 0;
      @(posedge clk);
   endtask
   task automatic rreg(input logic [15:0] a, input logic [7:0] exp);
      rd <= 1; addr <= {16'h1234, a};
      @(posedge clk); rd <= 0;
      #1 chk("read data", {8'h00, exp}, {8'h00, rdata});
      @(posedge clk);
   endtask
   // strobe one channel, optionally with a staged write in the very same cycle
   task automatic strobe(input int ch, input logic w, input logic [15:0] a, input logic [7:0] v,
                         input logic [15:0] exp_pins, input logic [3:0] exp_dma);
      fire <= 4'h1 << ch;
      @(posedge clk); fire <= 4'h0;
      wr <= w; addr <= {16'h0000, a}; wdata <= v;
      @(posedge clk); wr <= 0;
      #1 chk("pins", exp_pins, pin_out);
      chk("dma", {12'h000, exp_dma}, {12'h000, dma});
      @(posedge clk);
   endtask
   task automatic end_sim();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #20000;
      miscompares++;
      end_sim();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      foreach (rows[i]) rreg(rows[i].addr, rows[i].exp);
      $display("test reset values done");
      wreg(ADDR_OE_LOW, 8'h01);
      wreg(ADDR_STAGED_LOW, 8'h01);
      strobe(0, 0, 0, 0, 16'h0000, 4'h0);
      strobe(3, 0, 0, 0, 16'h0001, 4'hf);
      $display("test reset trigger done");
      wreg(ADDR_LOW_DIR, 8'hff);
      wreg(ADDR_HIGH_DIR, 8'hff);
      chk("enables", 16'hffff, pin_oe);
      wreg(ADDR_OE_LOW, 8'h0f);
      wreg(ADDR_OE_HIGH, 8'hff);
      wreg(ADDR_TRIG_SEL, 8'ha4);
      wreg(ADDR_STAGED_LOW, 8'h55);
      wreg(ADDR_STAGED_G0, 8'h0a);
      rreg(ADDR_STAGED_LOW, 8'h5f);
      rreg(ADDR_STAGED_G0, 8'hfa);
      wreg(ADDR_STAGED_HIGH, 8'h3c);
      rreg(ADDR_STAGED_HIGH, 8'h3c);
      rreg(ADDR_STAGED_G2, 8'hff);
      strobe(1, 0, 0, 0, 16'h0001, 4'h2);
      strobe(0, 0, 0, 0, 16'h000a, 4'h1);
      $display("test split groups done");
      wreg(ADDR_LOW_VALUE, 8'hf5);
      rreg(ADDR_LOW_VALUE, 8'hfa);
      strobe(2, 1, ADDR_STAGED_HIGH, 8'h99, 16'h3cfa, 4'hc);
      strobe(2, 0, 0, 0, 16'h99fa, 4'hc);
      $display("test port and collision done");
      // group 0 non-overlap: falls at the strobe, rises one margin later
      wreg(ADDR_MODE, 8'h01);
      rreg(ADDR_MODE, 8'hf1);
      wreg(ADDR_STAGED_G0, 8'h05);
      strobe(0, 0, 0, 0, 16'h99f0, 4'h1);
      #1 chk("margin rise", 16'h99f5, pin_out);
      @(posedge clk);
      $display("test non-overlap done");
      stby <= 1;
      @(posedge clk); stby <= 0;
      #1 chk("standby pins", 16'h0000, pin_out);
      @(posedge clk);
      rreg(ADDR_TRIG_SEL, RST_TRIG_SEL);
      rreg(ADDR_STAGED_HIGH, 8'h00);
      rreg(ADDR_MODE, RST_MODE);
      $display("test standby done");
      // directions cleared, so port values read the synchronised pins
      pins <= 16'h5aa5;
      repeat (6) @(posedge clk);
      rreg(ADDR_LOW_VALUE, 8'ha5);
      rreg(ADDR_HIGH_VALUE, 8'h5a);
      $display("test pin read done");
      end_sim();
   end
endmodule
